/* src/axis_position_limit_monitor.sv */
// position limit supervision: positioning range, software and hardware limits
// assumes motion inputs come from control logic on mclk, switch pins are async
`timescale 1ns/1ns
`default_nettype none

// Function
// RQ1: positioning range is -786432 to 786431 user units with default scaling.
// RQ2: only absolute profile position moves are refused beyond the range.
// RQ3: passing a range limit clears the homed-valid flag.
// RQ4: relative move predicted to overtravel: zero position at start, clear homed-valid.
// RQ5: software limits act only while homed-valid is set.
// RQ6: software limit enable: 0 none, 1 positive, 2 negative, 3 both; default 0.
// RQ7: software limit trigger sets bit 2 of latched signal status.
// RQ8: software limits compare the reference position, not the actual one.
// RQ9: positive soft limit defaults to max; out-of-range writes become max user value.
// RQ10: negative soft limit defaults to min, clamped the same way.
// RQ11: during movement an active hard limit stops the motor and is reported.
// RQ12: hard limit evaluation: 0 ignored, 1 normally closed, 2 normally open; default 1.
// RQ13: reference switch: 1 NC, 2 NO, default 1; evaluated only while homing.
// RQ14: jog motion leading back out of the limit region stays allowed.
// RQ15: installer should wire normally closed contacts so wire breaks show as active.
// RQ16: each enabled soft limit is checked every cycle; reaching the limit triggers.
module axis_position_limit_monitor (
	input  wire logic        mclk,
	input  wire logic        rst,
	// switch pins
	input  wire logic        pos_hard_limit_input,
	input  wire logic        neg_hard_limit_input,
	input  wire logic        home_switch_input,
	// motion state from the controller
	input  wire logic [31:0] reference_position,
	input  wire logic [31:0] actual_position,
	input  wire logic        moving,
	input  wire logic        move_positive,
	input  wire logic        jog_mode,
	input  wire logic        homing_active,
	input  wire logic        homing_done,
	input  wire logic        move_start,
	input  wire logic        profile_position_mode,
	input  wire logic        move_absolute,
	input  wire logic [31:0] move_target,
	input  wire logic        status_clear,
	// parameter port
	input  wire logic        param_write,
	input  wire logic        param_read,
	input  wire logic [11:0] param_addr,
	input  wire logic [31:0] param_wdata,
	output logic      [31:0] param_rdata,
	output logic             param_ack,
	// status
	output logic             homed_valid,
	output logic             motor_stop,
	output logic             position_zero_request,
	output logic             target_refused,
	output logic             soft_limit_pos_hit,
	output logic             soft_limit_neg_hit,
	output logic             hard_limit_pos_hit,
	output logic             hard_limit_neg_hit,
	output logic             home_switch_active,
	output logic      [31:0] latched_signal_status
);
	import axis_limit_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic        pos_meta;
		logic        pos_sync;
		logic        neg_meta;
		logic        neg_sync;
		logic        home_meta;
		logic        home_sync;
		logic [15:0] soft_limit_enable;
		logic [31:0] soft_limit_positive;
		logic [31:0] soft_limit_negative;
		logic [15:0] home_switch_polarity;
		logic [15:0] neg_hard_limit_polarity;
		logic [15:0] pos_hard_limit_polarity;
		logic [31:0] latched_signal_status;
		logic [31:0] param_rdata;
		logic        param_ack;
		logic        homed_valid;
		logic        motor_stop;
		logic        position_zero_request;
		logic        target_refused;
		logic        soft_pos_hit;
		logic        soft_neg_hit;
		logic        hard_pos_hit;
		logic        hard_neg_hit;
		logic        home_active;
	} state_type;

	state_type state;
	state_type next_state;

	////////////////////////////////////////////////////////////////////////////////
	// helpers

	// contact evaluation; unknown codes behave as ignored so a bad write never trips
	function automatic logic contact_active(input logic [15:0] code, input logic level);
		contact_active = 1'b0;
		unique case (code)
			CONTACT_IGNORED: contact_active = 1'b0;
			CONTACT_NC:      contact_active = ~level;
			CONTACT_NO:      contact_active = level;
			default:         contact_active = 1'b0;
		endcase
	endfunction : contact_active

	// a written limit outside the user range becomes the range end
	function automatic logic [31:0] clamp_user(input logic [31:0] value,
			input logic [31:0] replacement);
		if ($signed(value) > $signed(USER_MAX) || $signed(value) < $signed(USER_MIN)) begin
			clamp_user = replacement;
		end else begin
			clamp_user = value;
		end
	endfunction : clamp_user

	////////////////////////////////////////////////////////////////////////////////
	// combinational datapath

	logic signed [32:0] predicted;
	logic signed [32:0] range_lo;
	logic signed [32:0] range_hi;
	logic               act_outside;
	logic               pred_outside;
	logic               target_outside;
	logic               hard_pos;
	logic               hard_neg;
	logic               soft_pos;
	logic               soft_neg;
	logic               soft_pos_en;
	logic               soft_neg_en;
	logic               limit_pos;
	logic               limit_neg;
	logic               jog_away;
	logic               homed_clear;

	always_comb begin
		next_state = state;

		// pins: the first stage feeds only the second
		next_state.pos_meta  = pos_hard_limit_input;
		next_state.pos_sync  = state.pos_meta;
		next_state.neg_meta  = neg_hard_limit_input;
		next_state.neg_sync  = state.neg_meta;
		next_state.home_meta = home_switch_input;
		next_state.home_sync = state.home_meta;

		// range checks on 33 bits so the sum of a relative move cannot wrap
		range_lo = $signed({RANGE_MIN[31], RANGE_MIN});
		range_hi = $signed({RANGE_MAX[31], RANGE_MAX});
		predicted = $signed({actual_position[31], actual_position})
			+ $signed({move_target[31], move_target});
		act_outside = $signed({actual_position[31], actual_position}) > range_hi
			|| $signed({actual_position[31], actual_position}) < range_lo; // RQ1
		pred_outside = predicted > range_hi || predicted < range_lo; // RQ4
		target_outside = $signed({move_target[31], move_target}) > range_hi
			|| $signed({move_target[31], move_target}) < range_lo; // RQ2

		// hard limit contacts
		hard_pos = contact_active(state.pos_hard_limit_polarity, state.pos_sync); // RQ12
		hard_neg = contact_active(state.neg_hard_limit_polarity, state.neg_sync); // RQ12

		// reference switch only while homing runs
		next_state.home_active = homing_active
			&& contact_active(state.home_switch_polarity, state.home_sync); // RQ13

		// software limit direction enables
		soft_pos_en = 1'b0;
		soft_neg_en = 1'b0;
		unique case (state.soft_limit_enable)
			SOFT_NONE:     soft_pos_en = 1'b0; // RQ6
			SOFT_POS_ONLY: soft_pos_en = 1'b1; // RQ6
			SOFT_NEG_ONLY: soft_neg_en = 1'b1; // RQ6
			SOFT_BOTH: begin
				soft_pos_en = 1'b1; // RQ6
				soft_neg_en = 1'b1;
			end
			default:       soft_pos_en = 1'b0;
		endcase

		// reference position decides, so the motor may halt short of the limit
		soft_pos = state.homed_valid && soft_pos_en
			&& $signed(reference_position) >= $signed(state.soft_limit_positive); // RQ5 RQ8 RQ16
		soft_neg = state.homed_valid && soft_neg_en
			&& $signed(reference_position) <= $signed(state.soft_limit_negative); // RQ5 RQ8 RQ16
		next_state.soft_pos_hit = soft_pos;
		next_state.soft_neg_hit = soft_neg;
		next_state.hard_pos_hit = hard_pos;
		next_state.hard_neg_hit = hard_neg;

		// stop on any active limit while moving, unless jogging away from all of them
		limit_pos = hard_pos || soft_pos;
		limit_neg = hard_neg || soft_neg;
		jog_away = jog_mode && !(limit_pos && move_positive)
			&& !(limit_neg && !move_positive); // RQ14
		next_state.motor_stop = moving && (limit_pos || limit_neg) && !jog_away; // RQ11

		// profile position move start checks
		next_state.position_zero_request = move_start && profile_position_mode
			&& !move_absolute && pred_outside; // RQ4
		next_state.target_refused = move_start && profile_position_mode
			&& move_absolute && target_outside; // RQ2

		// zero point: lost on overtravel or predicted overtravel; a new homing wins
		homed_clear = act_outside || next_state.position_zero_request; // RQ3 RQ4
		if (homing_done) begin
			next_state.homed_valid = 1'b1;
		end else if (homed_clear) begin
			next_state.homed_valid = 1'b0; // RQ3
		end

		// latched status: a new event wins over a clear in the same cycle
		if (status_clear) begin
			next_state.latched_signal_status = '0;
		end
		if (soft_pos || soft_neg) begin
			next_state.latched_signal_status[SOFT_LIMIT_BIT] = 1'b1; // RQ7
		end
		if (moving && hard_pos) begin
			next_state.latched_signal_status[HARD_POS_BIT] = 1'b1; // RQ11
		end
		if (moving && hard_neg) begin
			next_state.latched_signal_status[HARD_NEG_BIT] = 1'b1; // RQ11
		end

		// parameter writes; 16-bit parameters take the low half
		if (param_write) begin
			unique case (param_addr)
				SOFT_LIMIT_ENABLE_ADDR:
					next_state.soft_limit_enable = param_wdata[15:0];
				SOFT_LIMIT_POSITIVE_ADDR:
					next_state.soft_limit_positive = clamp_user(param_wdata, USER_MAX); // RQ9
				SOFT_LIMIT_NEGATIVE_ADDR:
					next_state.soft_limit_negative = clamp_user(param_wdata, USER_MIN); // RQ10
				HOME_SWITCH_POLARITY_ADDR:
					next_state.home_switch_polarity = param_wdata[15:0];
				NEG_HARD_LIMIT_POLARITY_ADDR:
					next_state.neg_hard_limit_polarity = param_wdata[15:0];
				POS_HARD_LIMIT_POLARITY_ADDR:
					next_state.pos_hard_limit_polarity = param_wdata[15:0];
				default: ;
			endcase
		end

		// parameter reads answer one cycle later; unmapped addresses read zero
		next_state.param_ack = param_read || param_write;
		next_state.param_rdata = '0;
		if (param_read) begin
			unique case (param_addr)
				SOFT_LIMIT_ENABLE_ADDR:
					next_state.param_rdata = {16'h0000, state.soft_limit_enable};
				SOFT_LIMIT_POSITIVE_ADDR:
					next_state.param_rdata = state.soft_limit_positive;
				SOFT_LIMIT_NEGATIVE_ADDR:
					next_state.param_rdata = state.soft_limit_negative;
				HOME_SWITCH_POLARITY_ADDR:
					next_state.param_rdata = {16'h0000, state.home_switch_polarity};
				NEG_HARD_LIMIT_POLARITY_ADDR:
					next_state.param_rdata = {16'h0000, state.neg_hard_limit_polarity};
				POS_HARD_LIMIT_POLARITY_ADDR:
					next_state.param_rdata = {16'h0000, state.pos_hard_limit_polarity};
				LATCHED_STATUS_ADDR:
					next_state.param_rdata = state.latched_signal_status;
				default:
					next_state.param_rdata = '0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// state register

	// reset loads constants only; defaults are the factory settings
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state <= '0;
			// sync stages start at the idle level of an unpressed nc contact, so no false trip
			state.pos_meta <= 1'b1; // RQ12
			state.pos_sync <= 1'b1;
			state.neg_meta <= 1'b1;
			state.neg_sync <= 1'b1;
			state.home_meta <= 1'b1;
			state.home_sync <= 1'b1;
			state.soft_limit_enable <= SOFT_LIMIT_ENABLE_RESET; // RQ6
			state.soft_limit_positive <= SOFT_LIMIT_POSITIVE_RESET; // RQ9
			state.soft_limit_negative <= SOFT_LIMIT_NEGATIVE_RESET; // RQ10
			state.home_switch_polarity <= POLARITY_RESET; // RQ13
			state.neg_hard_limit_polarity <= POLARITY_RESET; // RQ12
			state.pos_hard_limit_polarity <= POLARITY_RESET; // RQ12
		end else begin
			state <= next_state;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs straight from the state register

	assign param_rdata           = state.param_rdata;
	assign param_ack             = state.param_ack;
	assign homed_valid           = state.homed_valid;
	assign motor_stop            = state.motor_stop;
	assign position_zero_request = state.position_zero_request;
	assign target_refused        = state.target_refused;
	assign soft_limit_pos_hit    = state.soft_pos_hit;
	assign soft_limit_neg_hit    = state.soft_neg_hit;
	assign hard_limit_pos_hit    = state.hard_pos_hit;
	assign hard_limit_neg_hit    = state.hard_neg_hit;
	assign home_switch_active    = state.home_active;
	assign latched_signal_status = state.latched_signal_status;

endmodule : axis_position_limit_monitor

`default_nettype wire

/* src/axis_limit_pkg.sv */
// constants and types for the axis position limit monitor
// assumes a parameter port with 12-bit parameter addresses and 32-bit data
package axis_limit_pkg;

	// parameter addresses, as printed
	localparam logic [11:0] SOFT_LIMIT_ENABLE_ADDR       = 12'h606;
	localparam logic [11:0] SOFT_LIMIT_POSITIVE_ADDR     = 12'h608;
	localparam logic [11:0] SOFT_LIMIT_NEGATIVE_ADDR     = 12'h60a;
	localparam logic [11:0] HOME_SWITCH_POLARITY_ADDR    = 12'h61c;
	localparam logic [11:0] NEG_HARD_LIMIT_POLARITY_ADDR = 12'h61e;
	localparam logic [11:0] POS_HARD_LIMIT_POLARITY_ADDR = 12'h620;
	localparam logic [11:0] LATCHED_STATUS_ADDR          = 12'h700;

	// reset values
	localparam logic [15:0] SOFT_LIMIT_ENABLE_RESET   = 16'h0000;
	localparam logic [31:0] SOFT_LIMIT_POSITIVE_RESET = 32'h7fff_ffff;
	localparam logic [31:0] SOFT_LIMIT_NEGATIVE_RESET = 32'h8000_0000;
	localparam logic [15:0] POLARITY_RESET            = 16'h0001;

	// positioning range with default scaling: -786432 .. 786431 usr
	localparam logic [31:0] RANGE_MIN = 32'hfff4_0000;
	localparam logic [31:0] RANGE_MAX = 32'h000b_ffff;

	// permissible user range for the software limits
	localparam logic [31:0] USER_MIN = 32'h8000_0000;
	localparam logic [31:0] USER_MAX = 32'h7fff_ffff;

	// latched signal status bit positions
	localparam int HARD_NEG_BIT = 0;
	localparam int HARD_POS_BIT = 1;
	localparam int SOFT_LIMIT_BIT = 2;

	// software limit enable codes
	typedef enum logic [15:0] {
		SOFT_NONE     = 16'h0000,
		SOFT_POS_ONLY = 16'h0001,
		SOFT_NEG_ONLY = 16'h0002,
		SOFT_BOTH     = 16'h0003
	} soft_mode_type;

	// switch contact evaluation codes
	typedef enum logic [15:0] {
		CONTACT_IGNORED = 16'h0000,
		CONTACT_NC      = 16'h0001,
		CONTACT_NO      = 16'h0002
	} contact_type;

endpackage : axis_limit_pkg

/* testbench/switch_contacts.sv */
// model of the limit and reference switch contacts wired to the pins
// assumes the bench says which switch is pressed and which contact kind is fitted
`timescale 1ns/1ns
`default_nettype none
module switch_contacts (
	input  wire logic [2:0] pressed,
	input  wire logic [2:0] nc_wired,
	input  wire logic       wire_break,
	output logic      [2:0] pin
);
	////////////////////////////////////////////////////////////////
	// bit 0 positive, bit 1 negative, bit 2 home; a cut wire reads 0, so an nc input trips
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			pin[i] = wire_break ? 1'b0 : (nc_wired[i] ? !pressed[i] : pressed[i]);
		end
	end
endmodule : switch_contacts
`default_nettype wire

/* testbench/axis_limit_chk.sv */
// temporal checks on the ports of the axis position limit monitor
// assumes it is bound to the top module, one clock, async active-high reset
`timescale 1ns/1ns
`default_nettype none
module axis_limit_chk (
	input wire logic        mclk,
	input wire logic        rst,
	input wire logic        param_write,
	input wire logic        param_read,
	input wire logic        param_ack,
	input wire logic [31:0] actual_position,
	input wire logic [31:0] move_target,
	input wire logic        move_start,
	input wire logic        profile_position_mode,
	input wire logic        move_absolute,
	input wire logic        homing_done,
	input wire logic        homing_active,
	input wire logic        moving,
	input wire logic        jog_mode,
	input wire logic        homed_valid,
	input wire logic        motor_stop,
	input wire logic        position_zero_request,
	input wire logic        target_refused,
	input wire logic        soft_limit_pos_hit,
	input wire logic        soft_limit_neg_hit,
	input wire logic        hard_limit_pos_hit,
	input wire logic        home_switch_active,
	input wire logic [31:0] latched_signal_status
);
	import axis_limit_pkg::*;
	logic signed [32:0] landing;
	logic               rel_over;
	logic               abs_out;
	////////////////////////////////////////////////////////////////
	// landing point in 33 bits so a long relative distance cannot wrap
	assign landing  = $signed(actual_position) + $signed(move_target);
	assign rel_over = landing > 33'sh0_000b_ffff || landing < 33'sh1_fff4_0000;
	assign abs_out  = $signed(move_target) > $signed(RANGE_MAX)
		|| $signed(move_target) < $signed(RANGE_MIN);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	chk_ack_follows: assert property ((param_write || param_read) |=> param_ack)
		else $error("no acknowledge after a parameter access");
	chk_ack_cause: assert property (param_ack |-> $past(param_write || param_read))
		else $error("acknowledge without an access");
	chk_rel_zero: assert property (move_start && profile_position_mode && !move_absolute
		&& rel_over && !homing_done |=> position_zero_request && !homed_valid)
		else $error("relative overtravel not zeroed");
	chk_abs_refuse: assert property (move_start && profile_position_mode
		&& move_absolute && abs_out |=> target_refused)
		else $error("absolute target outside range accepted");
	chk_soft_gate: assert property (!homed_valid [*2]
		|-> !soft_limit_pos_hit && !soft_limit_neg_hit)
		else $error("software limit active without zero point");
	chk_soft_latch: assert property ((soft_limit_pos_hit || soft_limit_neg_hit)
		|-> ##[0:1] latched_signal_status[SOFT_LIMIT_BIT])
		else $error("software limit not latched");
	chk_hard_stop: assert property (moving && !jog_mode ##1 hard_limit_pos_hit
		|-> motor_stop)
		else $error("hard limit did not stop the motor");
	chk_stop_cause: assert property (motor_stop |-> $past(moving))
		else $error("stop request without movement");
	chk_home_gate: assert property (home_switch_active |-> $past(homing_active))
		else $error("reference switch evaluated outside homing");
	cover property (position_zero_request);
	cover property (motor_stop);
	cover property (soft_limit_pos_hit);
endmodule : axis_limit_chk
`default_nettype wire

/* testbench/axis_position_limit_monitor_tb.sv */
// self-checking bench for the axis position limit monitor
// assumes the contact model and checker files are compiled before this one
`timescale 1ns/1ns
`default_nettype none
module axis_position_limit_monitor_tb;
	import axis_limit_pkg::*;
	logic mclk, rst, moving, move_positive, jog_mode, homing_active, homing_done;
	logic move_start, profile_position_mode, move_absolute, status_clear;
	logic param_write, param_read, param_ack, wire_break, homed_valid, motor_stop;
	logic position_zero_request, target_refused, soft_limit_pos_hit, soft_limit_neg_hit;
	logic hard_limit_pos_hit, hard_limit_neg_hit, home_switch_active;
	logic [31:0] reference_position, actual_position, move_target, param_wdata;
	logic [31:0] param_rdata, latched_signal_status;
	logic [11:0] param_addr;
	logic [2:0]  pressed, nc_wired, pin;
	int          n_fail, checks_done, cycles;
	////////////////////////////////////////////////////////////////
	// contacts, design and clock
	switch_contacts i_sw (.pressed, .nc_wired, .wire_break, .pin);
	axis_position_limit_monitor i_dut (.mclk, .rst, .pos_hard_limit_input(pin[0]),
		.neg_hard_limit_input(pin[1]), .home_switch_input(pin[2]), .reference_position,
		.actual_position, .moving, .move_positive, .jog_mode, .homing_active, .homing_done,
		.move_start, .profile_position_mode, .move_absolute, .move_target, .status_clear,
		.param_write, .param_read, .param_addr, .param_wdata, .param_rdata, .param_ack,
		.homed_valid, .motor_stop, .position_zero_request, .target_refused,
		.soft_limit_pos_hit, .soft_limit_neg_hit, .hard_limit_pos_hit, .hard_limit_neg_hit,
		.home_switch_active, .latched_signal_status);
	always #25 mclk = ~mclk;
	// a hang is cut short well above the some 114 cycles the tests need
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 3000) begin
			n_fail++;
			close_out();
		end
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#5;
	endtask : cyc
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t %s", $time, what);
		end
	endtask : chk
	// each access ends one idle cycle later so strobes never toggle twice in a step
	task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
		param_write = w;
		param_read = !w;
		param_addr = a;
		param_wdata = d;
		cyc(1);
		param_write = 1'b0;
		param_read = 1'b0;
		chk(param_ack, 1'b1, "no acknowledge");
		if (!w) chk(param_rdata, d, "read value");
		cyc(1);
	endtask : acc
	task automatic mv(input logic ab, input logic [31:0] t, input logic z, input logic r);
		move_start = 1'b1;
		move_absolute = ab;
		move_target = t;
		cyc(1);
		move_start = 1'b0;
		chk(position_zero_request, z, "zero request");
		chk(target_refused, r, "refusal");
		cyc(1);
	endtask : mv
	task automatic home_now();
		homing_done = 1'b1;
		cyc(1);
		homing_done = 1'b0;
	endtask : home_now
	task automatic t_regs();
		acc(0, SOFT_LIMIT_ENABLE_ADDR, 32'h0000_0000);
		acc(0, SOFT_LIMIT_POSITIVE_ADDR, 32'h7fff_ffff);
		acc(0, SOFT_LIMIT_NEGATIVE_ADDR, 32'h8000_0000);
		acc(0, HOME_SWITCH_POLARITY_ADDR, 32'h0000_0001);
		acc(0, NEG_HARD_LIMIT_POLARITY_ADDR, 32'h0000_0001);
		acc(0, POS_HARD_LIMIT_POLARITY_ADDR, 32'h0000_0001);
		acc(0, 12'h7f0, 32'h0000_0000);
		$display("t_regs done");
	endtask : t_regs
	task automatic t_range();
		home_now();
		chk(homed_valid, 1'b1, "homing done");
		mv(1, 32'h000b_ffff, 0, 0);
		mv(1, 32'h000c_0000, 0, 1);
		profile_position_mode = 1'b0;
		mv(1, 32'h000c_0000, 0, 0);
		profile_position_mode = 1'b1;
		mv(1, 32'hfff3_ffff, 0, 1);
		mv(0, 32'h0000_03e8, 0, 0);
		actual_position = 32'h000b_fe30;
		mv(0, 32'h0000_03e8, 1, 0);
		chk(homed_valid, 1'b0, "zero point kept");
		home_now();
		actual_position = 32'h000c_0000;
		cyc(2);
		chk(homed_valid, 1'b0, "overtravel kept zero point");
		actual_position = 32'h0000_0000;
		$display("t_range done");
	endtask : t_range
	task automatic t_soft();
		home_now();
		acc(1, SOFT_LIMIT_POSITIVE_ADDR, 32'h0000_03e8);
		acc(1, SOFT_LIMIT_NEGATIVE_ADDR, 32'hffff_fc18);
		for (int m = 0; m < 4; m++) begin
			acc(1, SOFT_LIMIT_ENABLE_ADDR, 32'(m));
			reference_position = 32'h0000_03e8;
			cyc(2);
			chk(soft_limit_pos_hit, m[0], "positive soft limit mode");
			reference_position = 32'hffff_fc18;
			cyc(2);
			chk(soft_limit_neg_hit, m[1], "negative soft limit mode");
		end
		reference_position = 32'h0000_03e7;
		actual_position = 32'h0000_03e8;
		cyc(2);
		chk(soft_limit_pos_hit, 1'b0, "actual position used");
		reference_position = 32'h0000_03e8;
		cyc(2);
		chk(soft_limit_pos_hit, 1'b1, "limit reached not caught");
		chk(latched_signal_status[SOFT_LIMIT_BIT], 1'b1, "soft bit");
		actual_position = 32'h000c_0000;
		cyc(2);
		actual_position = 32'h0000_0000;
		status_clear = 1'b1;
		cyc(1);
		status_clear = 1'b0;
		cyc(2);
		chk(soft_limit_pos_hit, 1'b0, "soft limit without zero point");
		chk(latched_signal_status[SOFT_LIMIT_BIT], 1'b0, "soft bit after clear");
		$display("t_soft done");
	endtask : t_soft
	task automatic t_hard();
		moving = 1'b1;
		pressed = 3'b001;
		cyc(4);
		chk(hard_limit_pos_hit, 1'b1, "nc contact");
		chk(motor_stop, 1'b1, "no stop");
		chk(latched_signal_status[HARD_POS_BIT], 1'b1, "hard bit");
		jog_mode = 1'b1;
		cyc(2);
		chk(motor_stop, 1'b0, "jog out refused");
		move_positive = 1'b1;
		cyc(2);
		chk(motor_stop, 1'b1, "jog into limit not stopped");
		move_positive = 1'b0;
		jog_mode = 1'b0;
		acc(1, POS_HARD_LIMIT_POLARITY_ADDR, 32'h0000_0002);
		nc_wired = 3'b110;
		cyc(4);
		chk(hard_limit_pos_hit, 1'b1, "no contact");
		acc(1, POS_HARD_LIMIT_POLARITY_ADDR, 32'h0000_0000);
		cyc(4);
		chk(hard_limit_pos_hit, 1'b0, "ignored input");
		wire_break = 1'b1;
		cyc(4);
		chk(hard_limit_neg_hit, 1'b1, "broken nc wire");
		chk(latched_signal_status[HARD_NEG_BIT], 1'b1, "neg hard bit");
		acc(0, LATCHED_STATUS_ADDR, 32'h0000_0003);
		wire_break = 1'b0;
		pressed = 3'b000;
		moving = 1'b0;
		cyc(4);
		chk(hard_limit_neg_hit, 1'b0, "neg contact released");
		$display("t_hard done");
	endtask : t_hard
	task automatic t_home();
		pressed = 3'b100;
		cyc(4);
		chk(home_switch_active, 1'b0, "home outside homing");
		homing_active = 1'b1;
		cyc(2);
		chk(home_switch_active, 1'b1, "home while homing");
		homing_active = 1'b0;
		pressed = 3'b000;
		$display("t_home done");
	endtask : t_home
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : close_out
	// main sequence: all inputs defined at time zero, reset held ten cycles
	initial begin
		{mclk, moving, move_positive, jog_mode, homing_active, homing_done} = '0;
		{move_start, move_absolute, status_clear, param_write, param_read} = '0;
		{wire_break, pressed, param_addr, param_wdata, move_target} = '0;
		{reference_position, actual_position} = '0;
		{rst, profile_position_mode, nc_wired} = 5'b1_1111;
		cyc(10);
		rst = 1'b0;
		t_regs();
		t_range();
		t_soft();
		t_hard();
		t_home();
		close_out();
	end
endmodule : axis_position_limit_monitor_tb
bind axis_position_limit_monitor axis_limit_chk i_chk (.mclk, .rst, .param_write, .param_read,
	.param_ack, .actual_position, .move_target, .move_start, .profile_position_mode,
	.move_absolute, .homing_done, .homing_active, .moving, .jog_mode, .homed_valid,
	.motor_stop, .position_zero_request, .target_refused, .soft_limit_pos_hit,
	.soft_limit_neg_hit, .hard_limit_pos_hit, .home_switch_active, .latched_signal_status);
`default_nettype wire
